// >>> adcsp_cfg.svh
/*
 holds the constants of the serial output port: widths, pin positions,
 register offsets, field positions, reset values and sclk timing.
 assumes it is included by its bare name wherever a constant is used.
*/
`ifndef ADCSP_CFG_SVH
`define ADCSP_CFG_SVH

// ------------------------------------------------------------
// data and timing
// ------------------------------------------------------------
`define ADCSP_W        16
`define ADCSP_NBITS    5'h10
`define ADCSP_QTR      3'h2
`define ADCSP_BITS_INT 16
`define ADCSP_QTR_INT  2

// ------------------------------------------------------------
// shared pin positions on the data bus
// ------------------------------------------------------------
`define ADCSP_P_CKSRC  4
`define ADCSP_P_SPOL   5
`define ADCSP_P_INV    6
`define ADCSP_P_RDC    7
`define ADCSP_P_SDO    8
`define ADCSP_P_SCLK   9
`define ADCSP_P_SYNC   10

// ------------------------------------------------------------
// register map (byte offsets) and control fields
// ------------------------------------------------------------
`define ADCSP_OFS_CTRL   4'h0
`define ADCSP_OFS_RESULT 4'h4
`define ADCSP_OFS_STATUS 4'h8
`define ADCSP_CTRL_W     2
`define ADCSP_C_IFSEL    0
`define ADCSP_C_FMT      1
`define ADCSP_CTRL_RST   2'h2

`endif

// >>> adcsp_fifo.sv
/*
 holds the result fifo between the register bus and the shifter.
 assumes one clock; pop and push follow valid/ready handshakes.
*/
module adcsp_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);

	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} adcsp_fifo_t;

	adcsp_fifo_t st_r;
	adcsp_fifo_t st_nxt;
	logic        push;
	logic        pop;

	// ------------------------------------------------------------
	// pointers wrap at the depth, so any depth of two or more works
	// ------------------------------------------------------------
	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		inc = (p == AW'(D - 1)) ? '0 : p + AW'(1);
	endfunction

	always_comb begin
		st_nxt = st_r;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			st_nxt.mem[st_r.wp] = in_data;
			st_nxt.wp = inc(st_r.wp);
		end
		if (pop) begin
			st_nxt.rp = inc(st_r.rp);
		end
		if (push && !pop) begin
			st_nxt.cnt = st_r.cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			st_nxt.cnt = st_r.cnt - (AW+1)'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign in_ready = st_r.cnt != (AW+1)'(D);
	assign out_valid = st_r.cnt != '0;
	assign out_data = st_r.mem[st_r.rp];

endmodule

// >>> adcsp_host.sv
/*
 holds a behavioural host for slave mode: it makes the external serial
 clock, the active-low read strobe and an upstream chain data stream.
 assumes it is stepped by mclk and that sdo is the port's serial output.
*/
module adcsp_host (
	input  wire logic mclk,
	input  wire logic inv,
	input  wire logic sdo,
	output logic      sclk,
	output logic      read_n,
	output logic      sdin
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		sclk = 1'b0;
		read_n = 1'b1;
		sdin = 1'b0;
	end

	// ------------------------------------------------------------
	// one read of 32 periods of 160 ns; clock stands still outside it
	// ------------------------------------------------------------
	task automatic read_frames(input logic [15:0] chain,
		output logic [31:0] rx);
		rx = 32'h0000_0000;
		@(posedge mclk) sclk <= inv;
		repeat (16) @(posedge mclk);
		read_n <= 1'b0;
		repeat (16) @(posedge mclk);
		// two words: own result, then one chained part
		for (int p = 0; p < 32; p++) begin
			@(posedge mclk) sclk <= ~inv;
			repeat (8) @(posedge mclk);
			sclk <= inv;
			rx = {rx[30:0], sdo};
			// upstream changes mid-period; inverse after its word ends
			sdin <= (p < 16) ? chain[15 - p] : ~sdin;
			repeat (7) @(posedge mclk);
		end
		@(posedge mclk) read_n <= 1'b1;
		sdin <= ~sdin;
	endtask
endmodule

// >>> adcsp_pkg.sv
/*
 holds the types shared by the serial output port.
 assumes nothing of its surroundings.
*/
package adcsp_pkg;

	// ------------------------------------------------------------
	// frame sequencer states, one bit apart from idle
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_MASTER = 2'h1,
		ST_SLAVE  = 2'h2
	} adcsp_state_t;

endpackage

// >>> adcsp_sync.sv
/*
 holds a three-stage synchroniser with agreement filter.
 assumes each input bit is a slow level from outside the mclk domain.
*/
module adcsp_sync #(
	parameter int W = 6
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} adcsp_sync_t;

	adcsp_sync_t st_r;
	adcsp_sync_t st_nxt;

	// ------------------------------------------------------------
	// a bit changes only once stages two and three agree
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.q = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) |
			(st_r.q & (st_r.s2 ^ st_r.s3));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.q;

endmodule

// >>> adcsp_top.sv
/*
 holds the serial output port of a 16-bit converter: shared data pins,
 internal (master) and external (slave) serial clock, frame sync, chain
 input, result fifo and an avalon-mm register slave with waitrequest.
 assumes results arrive through the result register, conv_busy comes
 from the converter core on mclk, pins come from outside the domain.
*/
`include "adcsp_cfg.svh"

module adcsp_top #(
	parameter int W     = `ADCSP_W,
	parameter int DEPTH = 8
) (
	input  wire logic        MCLK,
	input  wire logic        SYS_RST,
	input  wire logic [3:0]  AV_ADDRESS,
	input  wire logic        AV_READ,
	input  wire logic        AV_WRITE,
	input  wire logic [31:0] AV_WRITEDATA,
	output logic      [31:0] AV_READDATA,
	output logic             AV_WAITREQUEST,
	input  wire logic        CONV_BUSY,
	input  wire logic        READ_N,
	input  wire logic [15:0] DATA_I,
	output logic      [15:0] DATA_O,
	output logic      [15:0] DATA_OE
);

	typedef struct packed {
		adcsp_pkg::adcsp_state_t st;
		logic [`ADCSP_CTRL_W-1:0] ctrl;
		logic [W-1:0]  last;
		logic [W-1:0]  sr;
		logic [4:0]    bits;
		logic [1:0]    qph;
		logic [2:0]    qcnt;
		logic          first;
		logic          sclk_prev;
		logic [15:0]   dout;
		logic [15:0]   doe;
		logic          wait_req;
		logic [31:0]   rdata;
	} adcsp_top_t;

	adcsp_top_t  st_r;
	adcsp_top_t  st_nxt;
	logic [5:0]  pin_q;
	logic        ext_s;
	logic        spol_s;
	logic        inv_s;
	logic        rdc_s;
	logic        sclk_s;
	logic        rd_n_s;
	logic        ifsel;
	logic        fmtsel;
	logic        fifo_iv;
	logic        fifo_ir;
	logic        fifo_ov;
	logic [W-1:0] fifo_od;
	logic        pop;
	logic        start_m;
	logic        start_s;
	logic        upd;
	logic        wr_res;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// twos complement is straight binary with the msb flipped
	function automatic logic [W-1:0] fmt(input logic [W-1:0] d,
		input logic ob);
		fmt = d;
		fmt[W-1] = d[W-1] ^ !ob;
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers and fifo
	// ------------------------------------------------------------
	adcsp_sync #(.W(6)) u_sync (
		.clk (MCLK),
		.rst (SYS_RST),
		.d   ({READ_N, DATA_I[`ADCSP_P_SCLK], DATA_I[`ADCSP_P_RDC],
			DATA_I[`ADCSP_P_INV], DATA_I[`ADCSP_P_SPOL],
			DATA_I[`ADCSP_P_CKSRC]}),
		.q   (pin_q)
	);

	assign {rd_n_s, sclk_s, rdc_s, inv_s, spol_s, ext_s} = pin_q;

	// a full fifo holds waitrequest high on a result write, stalling the bus master
	adcsp_fifo #(.W(W), .D(DEPTH)) u_fifo (
		.clk       (MCLK),
		.rst       (SYS_RST),
		.in_valid  (fifo_iv),
		.in_ready  (fifo_ir),
		.in_data   (AV_WRITEDATA[W-1:0]),
		.out_valid (fifo_ov),
		.out_ready (pop),
		.out_data  (fifo_od)
	);

	assign ifsel = st_r.ctrl[`ADCSP_C_IFSEL];
	assign fmtsel = st_r.ctrl[`ADCSP_C_FMT];

	// ------------------------------------------------------------
	// frame start conditions and external edge detect
	// ------------------------------------------------------------
	// internal clock: the read-mode pin gates the start on busy
	assign start_m = ifsel && !ext_s && fifo_ov &&
		(rdc_s ? CONV_BUSY : !CONV_BUSY);
	assign start_s = ifsel && ext_s && !rd_n_s;
	// update edge is the rise, or the fall when inverted
	assign upd = inv_s ? (st_r.sclk_prev && !sclk_s)
		: (!st_r.sclk_prev && sclk_s);
	assign wr_res = AV_WRITE && AV_ADDRESS == `ADCSP_OFS_RESULT;
	// push only at the edge where waitrequest is seen low
	assign fifo_iv = !st_r.wait_req && wr_res;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		pop = 1'b0;
		st_nxt.sclk_prev = sclk_s;
		unique case (st_r.st)
			adcsp_pkg::ST_IDLE: begin
				if (!ifsel) begin
					// parallel mode shows each new result at once
					if (fifo_ov) begin
						pop = 1'b1;
						st_nxt.last = fifo_od;
					end
				end else if (start_m) begin
					pop = 1'b1;
					st_nxt.last = fifo_od;
					st_nxt.sr = fmt(fifo_od, fmtsel);
					st_nxt.bits = `ADCSP_NBITS;
					st_nxt.qph = 2'h0;
					st_nxt.qcnt = 3'h0;
					st_nxt.st = adcsp_pkg::ST_MASTER;
				end else if (start_s) begin
					// no new result: the old one is read again
					if (fifo_ov) begin
						pop = 1'b1;
						st_nxt.last = fifo_od;
						st_nxt.sr = fmt(fifo_od, fmtsel);
					end else begin
						st_nxt.sr = fmt(st_r.last, fmtsel);
					end
					st_nxt.first = 1'b1;
					st_nxt.st = adcsp_pkg::ST_SLAVE;
				end
			end
			adcsp_pkg::ST_MASTER: begin
				// four quarters per bit; data moves only at quarter 0
				if (st_r.qcnt == `ADCSP_QTR - 3'h1) begin
					st_nxt.qcnt = 3'h0;
					st_nxt.qph = st_r.qph + 2'h1;
					if (st_r.qph == 2'h3) begin
						st_nxt.sr = st_r.sr << 1;
						st_nxt.bits = st_r.bits - 5'h1;
						if (st_r.bits == 5'h1) begin
							st_nxt.st = adcsp_pkg::ST_IDLE;
						end
					end
				end else begin
					st_nxt.qcnt = st_r.qcnt + 3'h1;
				end
			end
			adcsp_pkg::ST_SLAVE: begin
				if (rd_n_s || !ifsel || !ext_s) begin
					st_nxt.st = adcsp_pkg::ST_IDLE;
				end else if (upd) begin
					// first edge presents the msb; later ones shift
					if (st_r.first) begin
						st_nxt.first = 1'b0;
					end else begin
						st_nxt.sr = {st_r.sr[W-2:0], rdc_s};
					end
				end
			end
			default: begin
				st_nxt.st = adcsp_pkg::ST_IDLE;
			end
		endcase

		// pins: parallel bus, or serial roles on the shared bits
		if (!ifsel) begin
			st_nxt.dout = 16'(fmt(st_r.last, fmtsel));
			st_nxt.doe = 16'hFFFF;
		end else begin
			st_nxt.dout = 16'h0000;
			st_nxt.doe = 16'h0000;
			st_nxt.dout[`ADCSP_P_SDO] = (st_r.st != adcsp_pkg::ST_IDLE)
				&& st_r.sr[W-1];
			st_nxt.doe[`ADCSP_P_SDO] = 1'b1;
			st_nxt.dout[`ADCSP_P_SCLK] = ((st_r.st ==
				adcsp_pkg::ST_MASTER) && ^st_r.qph) ^ inv_s;
			st_nxt.doe[`ADCSP_P_SCLK] = !ext_s;
			st_nxt.dout[`ADCSP_P_SYNC] = (st_r.st ==
				adcsp_pkg::ST_MASTER) ^ spol_s;
			st_nxt.doe[`ADCSP_P_SYNC] = 1'b1;
		end

		// bus: one wait cycle, longer while a result push finds it full
		st_nxt.wait_req = !(st_r.wait_req && (AV_READ || AV_WRITE)
			&& (!wr_res || fifo_ir));
		if (st_r.wait_req && AV_READ) begin
			unique case (AV_ADDRESS)
				`ADCSP_OFS_CTRL: st_nxt.rdata = 32'(st_r.ctrl);
				`ADCSP_OFS_RESULT: st_nxt.rdata = 32'(st_r.last);
				`ADCSP_OFS_STATUS: st_nxt.rdata = 32'({st_r.st !=
					adcsp_pkg::ST_IDLE, ext_s, !fifo_ir, !fifo_ov});
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end
		if (!st_r.wait_req && AV_WRITE &&
			AV_ADDRESS == `ADCSP_OFS_CTRL) begin
			st_nxt.ctrl = AV_WRITEDATA[`ADCSP_CTRL_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			st_r <= '0;
			st_r.ctrl <= `ADCSP_CTRL_RST;
			st_r.wait_req <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign AV_READDATA = st_r.rdata;
	assign AV_WAITREQUEST = st_r.wait_req;
	assign DATA_O = st_r.dout;
	assign DATA_OE = st_r.doe;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	localparam int FRM_CYC = `ADCSP_BITS_INT * 4 * `ADCSP_QTR_INT;

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (SYS_RST);

	chk_par_pins: assert property (
		!ifsel |=> DATA_OE == 16'hFFFF)
		else $error("parallel mode left a data pin undriven");

	chk_sync_level: assert property (
		(ifsel && st_r.st == adcsp_pkg::ST_MASTER) |=>
		DATA_O[`ADCSP_P_SYNC] == !$past(spol_s))
		else $error("frame sync not at its active level");

	chk_sclk_dir: assert property (
		ifsel |=> DATA_OE[`ADCSP_P_SCLK] == !$past(ext_s))
		else $error("sclk pin direction wrong for clock source");

	chk_msb_load: assert property (
		(st_r.st == adcsp_pkg::ST_IDLE && start_m) |=>
		st_r.sr == $past(fmt(fifo_od, fmtsel)))
		else $error("shift register not loaded with formatted result");

	chk_frame_len: assert property (
		(st_r.st == adcsp_pkg::ST_IDLE && start_m) |=>
		##(FRM_CYC - 1) st_r.st == adcsp_pkg::ST_MASTER
		##1 st_r.st == adcsp_pkg::ST_IDLE)
		else $error("master frame length wrong");

	chk_read_mode: assert property (
		(st_r.st == adcsp_pkg::ST_MASTER &&
		$past(st_r.st) == adcsp_pkg::ST_IDLE) |->
		$past(CONV_BUSY) == $past(rdc_s))
		else $error("master read started in the wrong read mode");

	chk_data_hold: assert property (
		(st_r.st == adcsp_pkg::ST_MASTER &&
		$past(st_r.st) == adcsp_pkg::ST_MASTER &&
		$changed(DATA_O[`ADCSP_P_SCLK])) |-> $stable(DATA_O[`ADCSP_P_SDO]))
		else $error("serial data moved on an internal sclk edge");

	chk_ext_edge: assert property (
		(st_r.st == adcsp_pkg::ST_SLAVE && !upd) |=>
		st_r.sr == $past(st_r.sr))
		else $error("slave data changed off the update edge");

	chk_chain_in: assert property (
		(st_r.st == adcsp_pkg::ST_SLAVE && st_nxt.st ==
		adcsp_pkg::ST_SLAVE && upd && !st_r.first) |=>
		st_r.sr[0] == $past(rdc_s))
		else $error("chain input not taken into the shifter");

	// ------------------------------------------------------------
	// checks on the shared pins and the slave start
	// ------------------------------------------------------------
	// mode inputs share pins with data bits: driving them would fight
	chk_mode_inputs: assert property (
		ifsel |=> !DATA_OE[`ADCSP_P_RDC] && !DATA_OE[`ADCSP_P_INV]
		&& !DATA_OE[`ADCSP_P_SPOL] && !DATA_OE[`ADCSP_P_CKSRC])
		else $error("serial mode drove a mode input pin");

	chk_sync_idle: assert property (
		(ifsel && st_r.st != adcsp_pkg::ST_MASTER) |=>
		DATA_O[`ADCSP_P_SYNC] == $past(spol_s))
		else $error("frame sync active outside a master frame");

	chk_sclk_rest: assert property (
		(ifsel && !ext_s && st_r.st != adcsp_pkg::ST_MASTER) |=>
		DATA_O[`ADCSP_P_SCLK] == $past(inv_s))
		else $error("internal sclk rest level ignores inversion");

	chk_slave_start: assert property (
		(st_r.st == adcsp_pkg::ST_IDLE && start_s) |=>
		st_r.st == adcsp_pkg::ST_SLAVE && st_r.first)
		else $error("external read did not start a slave frame");

	chk_slave_load: assert property (
		(st_r.st == adcsp_pkg::ST_IDLE && start_s && fifo_ov) |=>
		st_r.sr[W-1] == ($past(fifo_od[W-1]) ^ !$past(fmtsel)))
		else $error("slave frame msb not formatted");

	chk_par_msb: assert property (
		!ifsel |=> DATA_O[W-1] ==
		($past(st_r.last[W-1]) ^ !$past(fmtsel)))
		else $error("parallel msb not formatted");

endmodule

// >>> adcsp_top_test.sv
/*
 holds the self-checking bench of the serial output port.
 assumes the design files and the host model are compiled first.
*/
module adcsp_top_test;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// stimulus and wiring
	// ------------------------------------------------------------
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  av_address = 4'h0;
	logic        av_read = 1'b0;
	logic        av_write = 1'b0;
	logic [31:0] av_writedata = 32'h0000_0000;
	logic [31:0] av_readdata;
	logic        av_waitrequest;
	logic        conv_busy = 1'b0;
	logic [15:0] cfg = 16'h0000;
	logic [15:0] data_i;
	logic [15:0] data_o;
	logic [15:0] data_oe;
	logic        h_sclk;
	logic        h_read_n;
	logic        h_sdin;
	int          failures = 0;
	int          checked = 0;

	always #5 mclk = ~mclk;

	// host takes over clock and chain pins only with external clock
	assign data_i = {cfg[15:10], cfg[4] ? h_sclk : cfg[9], cfg[8],
		cfg[4] ? h_sdin : cfg[7], cfg[6:0]};

	adcsp_top #(.W(16), .DEPTH(8)) i_adcsp_top (
		.MCLK          (mclk),
		.SYS_RST       (sys_rst),
		.AV_ADDRESS    (av_address),
		.AV_READ       (av_read),
		.AV_WRITE      (av_write),
		.AV_WRITEDATA  (av_writedata),
		.AV_READDATA   (av_readdata),
		.AV_WAITREQUEST(av_waitrequest),
		.CONV_BUSY     (conv_busy),
		.READ_N        (h_read_n),
		.DATA_I        (data_i),
		.DATA_O        (data_o),
		.DATA_OE       (data_oe)
	);

	adcsp_host i_adcsp_host (
		.mclk  (mclk),
		.inv   (cfg[6]),
		.sdo   (data_o[8]),
		.sclk  (h_sclk),
		.read_n(h_read_n),
		.sdin  (h_sdin)
	);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, exp, input string msg);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	// request held until waitrequest is sampled low
	task automatic av(input logic wr, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		av_address <= a;
		av_write <= wr;
		av_read <= ~wr;
		av_writedata <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (av_waitrequest !== 1'b0 && n < 300);
		q = av_readdata;
		av_read <= 1'b0;
		av_write <= 1'b0;
		chk(n < 300, 1, "bus answer missing");
	endtask

	// follows one master frame and judges bits, sync and sclk
	task automatic master_frame(input logic inv, spol,
		input logic [15:0] exp);
		logic [15:0] rx;
		logic        sck;
		int          n, bits, act;
		n = 0;
		bits = 0;
		act = 0;
		rx = 16'h0000;
		while (data_o[10] !== ~spol && n < 2000) begin
			@(posedge mclk);
			n++;
		end
		sck = data_o[9];
		while (data_o[10] === ~spol && act < 400) begin
			@(posedge mclk);
			act++;
			if (data_o[9] !== sck && data_o[9] === ~inv) begin
				rx = {rx[14:0], data_o[8]};
				bits++;
			end
			if (data_o[9] !== sck && data_o[9] === inv)
				chk(data_o[8], rx[0], "bit moved in mid period");
			sck = data_o[9];
		end
		chk(bits, 16, "bit count");
		chk(rx, exp, "serial word");
		chk(act, 128, "frame sync length");
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic master_case(input logic inv, spol, rdc, fmt);
		logic [31:0] q;
		logic [15:0] w;
		cfg <= {8'h00, rdc, inv, spol, 1'b0, 4'h0};
		conv_busy <= ~rdc;
		av(1, 4'h0, {30'h0, fmt, 1'b1}, q);
		repeat (10) @(posedge mclk);
		chk(data_oe, 16'h0700, "master pin enables");
		for (int i = 0; i < 8; i++)
			av(1, 4'h4, 32'h1357 + i * 32'h2461, q);
		av(0, 4'h8, 0, q);
		chk(q[1:0], 2'h2, "fifo full flags");
		repeat (20) @(posedge mclk);
		chk(data_o[10], spol, "frame held back");
		conv_busy <= rdc;
		for (int i = 0; i < 8; i++) begin
			w = 16'h1357 + i * 16'h2461;
			master_frame(inv, spol, fmt ? w : w ^ 16'h8000);
		end
		av(0, 4'h8, 0, q);
		chk(q[0], 1'b1, "fifo empty after drain");
		$display("master case done");
	endtask

	task automatic slave_case(input logic inv);
		logic [31:0] q;
		logic [31:0] rx;
		cfg <= {8'h00, 1'b0, inv, 1'b0, 5'h10};
		av(1, 4'h0, 32'h3, q);
		repeat (10) @(posedge mclk);
		chk(data_oe, 16'h0500, "slave pin enables");
		av(1, 4'h4, 32'hC3A5, q);
		i_adcsp_host.read_frames(16'h5A96, rx);
		chk(rx, 32'hC3A5_5A96, "chained read");
		$display("slave case done");
	endtask

	task automatic parallel_case;
		logic [31:0] q;
		av(1, 4'h0, 32'h2, q);
		av(1, 4'h4, 32'h8001, q);
		repeat (10) @(posedge mclk);
		chk(data_o, 16'h8001, "parallel straight");
		chk(data_oe, 16'hFFFF, "parallel enables");
		av(1, 4'h0, 32'h0, q);
		repeat (10) @(posedge mclk);
		chk(data_o, 16'h0001, "parallel twos");
		av(0, 4'hC, 0, q);
		chk(q, 0, "unmapped read");
		av(0, 4'h0, 0, q);
		chk(q, 0, "control readback");
		$display("parallel case done");
	endtask

	task automatic close_out;
		$display("checks %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		logic [31:0] q;
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		av(0, 4'h0, 0, q);
		chk(q, 32'h2, "control reset value");
		chk(data_oe, 16'hFFFF, "reset to parallel");
		master_case(1'b0, 1'b0, 1'b0, 1'b1);
		master_case(1'b1, 1'b1, 1'b1, 1'b0);
		slave_case(1'b0);
		slave_case(1'b1);
		parallel_case;
		close_out;
	end

	// all scenarios need about 3400 cycles
	initial begin
		repeat (40000) @(posedge mclk);
		failures++;
		$display("wrong value at %0t: watchdog expired", $time);
		close_out;
	end
endmodule
